// [verilog/srp_pkg.sv]
// package of constants for the serial receive packetizer
// assumes a single 25 MHz core clock and synchronous active-low reset
package srp_pkg;
    localparam int          SRP_BUF_BYTES    = 1024;
    localparam int          SRP_CNT_W        = 11;
    localparam int          SRP_CLK_HZ       = 25000000;
    localparam int          SRP_MS_PER_S     = 1000;
    localparam int          SRP_CYC_PER_MS   = SRP_CLK_HZ / SRP_MS_PER_S;
    localparam logic [15:0] SRP_TCP_PORT_DEF = 16'h0FA1;
    localparam logic [1:0]  SRP_MODE_KEEP    = 2'h0;
    localparam logic [1:0]  SRP_MODE_PLUS1   = 2'h1;
    localparam logic [1:0]  SRP_MODE_PLUS2   = 2'h2;
    localparam logic [1:0]  SRP_MODE_STRIP   = 2'h3;
    localparam logic [1:0]  SRP_TRAIL_ONE    = 2'h1;
    localparam logic [1:0]  SRP_TRAIL_TWO    = 2'h2;
    typedef enum logic [1:0] {SRP_FILL, SRP_TRAIL, SRP_DRAIN} srp_state_t;
endpackage

// [verilog/srp_stream_if.sv]
// byte stream carrier with valid, ready and end-of-packet
// assumes the clock of the instantiating module
`timescale 1ns/1ps
interface srp_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    logic       last;
    modport src (output valid, output data, output last, input ready);
    modport snk (input valid, input data, input last, output ready);
endinterface

// [verilog/srp_skid.sv]
// two-entry buffer between packet drain and network side
// assumes core_clk and synchronous active-low reset
`timescale 1ns/1ps
module srp_skid (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // stream in
    srp_stream_if.snk in_s,
    // stream out
    output      logic       out_valid,
    output      logic [7:0] out_data,
    output      logic       out_last,
    input  wire logic       out_ready
);
    logic [8:0] ent_reg [2];
    logic [8:0] ent_next [2];
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic       push;
    logic       pop;

    assign in_s.ready = (cnt_reg != 2'h2);
    assign push       = in_s.valid && in_s.ready;
    assign pop        = out_valid && out_ready;
    assign out_valid  = (cnt_reg != 2'h0);
    assign out_data   = ent_reg[0][7:0];
    assign out_last   = ent_reg[0][8];

    always_comb begin
        ent_next[0] = ent_reg[0];
        ent_next[1] = ent_reg[1];
        cnt_next    = cnt_reg;
        if (pop) begin
            ent_next[0] = ent_reg[1];
        end
        if (push) begin
            if (cnt_reg - {1'b0, pop} == 2'h0) begin
                ent_next[0] = {in_s.last, in_s.data};
            end else begin
                ent_next[1] = {in_s.last, in_s.data};
            end
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ent_reg[0] <= 9'h000;
            ent_reg[1] <= 9'h000;
            cnt_reg    <= 2'h0;
        end else begin
            ent_reg[0] <= ent_next[0];
            ent_reg[1] <= ent_next[1];
            cnt_reg    <= cnt_next;
        end
    end
endmodule

// [verilog/srp_packetizer.sv]
// serial receive packetizer top: gathers bytes, releases packets
// assumes a byte receiver in front and a stream consumer behind
`timescale 1ns/1ps
module srp_packetizer
    import srp_pkg::*;
#(
    parameter int BUF_BYTES  = SRP_BUF_BYTES,
    parameter int CYC_PER_MS = SRP_CYC_PER_MS
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // serial byte input
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output      logic        rx_ready,
    // configuration
    input  wire logic [10:0] pkt_len_limit,
    input  wire logic [7:0]  marker1_value,
    input  wire logic        marker1_en,
    input  wire logic [7:0]  marker2_value,
    input  wire logic        marker2_en,
    input  wire logic [1:0]  marker_mode,
    input  wire logic [15:0] flush_timeout_ms,
    input  wire logic [15:0] tcp_port_cfg,
    // status
    output      logic [15:0] tcp_port,
    output      logic [10:0] fill_level,
    output      logic        pkt_release,
    // network side stream
    output      logic        net_valid,
    output      logic [7:0]  net_data,
    output      logic        net_last,
    input  wire logic        net_ready
);
    // ****************************************
    // buffer and control state
    // ****************************************
    logic [7:0]           mem_reg [BUF_BYTES];
    logic [SRP_CNT_W-1:0] cnt_reg, cnt_next;
    logic [SRP_CNT_W-1:0] rd_reg, rd_next;
    srp_state_t           st_reg, st_next;
    logic [1:0]           trail_reg, trail_next;
    logic [31:0]          cyc_reg, cyc_next;
    logic [15:0]          ms_reg, ms_next;
    logic [15:0]          port_reg;
    logic                 rel_reg, rel_next;
    logic                 wr_en;
    logic                 is_marker;
    logic                 len_hit;
    logic                 full_hit;
    logic                 tmo_hit;
    logic                 release_now;
    logic [SRP_CNT_W-1:0] wr_cnt;

    srp_stream_if drain_s ();

    // ****************************************
    // receive decisions
    // ****************************************
    assign rx_ready  = (st_reg != SRP_DRAIN);
    assign wr_en     = rx_valid && rx_ready;
    assign is_marker = marker1_en && (rx_data == marker1_value)
                     || marker1_en && marker2_en && (rx_data == marker2_value);
    assign wr_cnt    = (st_reg == SRP_FILL && is_marker && marker_mode == SRP_MODE_STRIP)
                     ? cnt_reg : cnt_reg + 11'h001;
    assign len_hit   = (pkt_len_limit != 11'h000) && (wr_cnt == pkt_len_limit);
    assign full_hit  = (wr_cnt == SRP_CNT_W'(BUF_BYTES));
    assign tmo_hit   = (flush_timeout_ms != 16'h0000) && (cnt_reg != 11'h000)
                     && (ms_reg >= flush_timeout_ms) && !wr_en;

    always_comb begin
        st_next     = st_reg;
        cnt_next    = cnt_reg;
        rd_next     = rd_reg;
        trail_next  = trail_reg;
        rel_next    = 1'b0;
        release_now = 1'b0;
        case (st_reg)
            SRP_FILL, SRP_TRAIL: begin
                if (wr_en) begin
                    cnt_next = wr_cnt;
                    if (st_reg == SRP_TRAIL) begin
                        trail_next = trail_reg - 2'h1;
                        if (trail_reg == 2'h1) begin
                            release_now = 1'b1;
                        end
                    end else if (is_marker) begin
                        case (marker_mode)
                            SRP_MODE_PLUS1: begin
                                st_next    = SRP_TRAIL;
                                trail_next = SRP_TRAIL_ONE;
                            end
                            SRP_MODE_PLUS2: begin
                                st_next    = SRP_TRAIL;
                                trail_next = SRP_TRAIL_TWO;
                            end
                            default: begin
                                release_now = 1'b1;
                            end
                        endcase
                    end
                    if (len_hit || full_hit) begin
                        release_now = 1'b1;
                    end
                end else if (tmo_hit) begin
                    release_now = 1'b1;
                end
                if (release_now) begin
                    rel_next = 1'b1;
                    rd_next  = 11'h000;
                    if (cnt_next == 11'h000) begin
                        st_next = SRP_FILL;
                    end else begin
                        st_next = SRP_DRAIN;
                    end
                end
            end
            SRP_DRAIN: begin
                if (drain_s.ready) begin
                    rd_next = rd_reg + 11'h001;
                    if (rd_reg + 11'h001 == cnt_reg) begin
                        st_next  = SRP_FILL;
                        cnt_next = 11'h000;
                    end
                end
            end
            default: begin
                st_next = SRP_FILL;
            end
        endcase
    end

    // ****************************************
    // idle timer in milliseconds
    // ****************************************
    always_comb begin
        cyc_next = cyc_reg;
        ms_next  = ms_reg;
        if (wr_en || st_reg == SRP_DRAIN || release_now) begin
            cyc_next = 32'h0000_0000;
            ms_next  = 16'h0000;
        end else if (cyc_reg == 32'(CYC_PER_MS - 1)) begin
            cyc_next = 32'h0000_0000;
            if (ms_reg != 16'hFFFF) begin
                ms_next = ms_reg + 16'h0001;
            end
        end else begin
            cyc_next = cyc_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_reg    <= SRP_FILL;
            cnt_reg   <= 11'h000;
            rd_reg    <= 11'h000;
            trail_reg <= 2'h0;
            rel_reg   <= 1'b0;
            cyc_reg   <= 32'h0000_0000;
            ms_reg    <= 16'h0000;
        end else begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            rd_reg    <= rd_next;
            trail_reg <= trail_next;
            rel_reg   <= rel_next;
            cyc_reg   <= cyc_next;
            ms_reg    <= ms_next;
        end
    end

    // ****************************************
    // byte storage, no reset needed
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (wr_en && (wr_cnt != cnt_reg)) begin
            mem_reg[cnt_reg[9:0]] <= rx_data;
        end
    end

    // ****************************************
    // listening port number
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            port_reg <= SRP_TCP_PORT_DEF;
        end else begin
            port_reg <= tcp_port_cfg;
        end
    end

    // ****************************************
    // drain toward network
    // ****************************************
    assign drain_s.valid = (st_reg == SRP_DRAIN);
    assign drain_s.data  = mem_reg[rd_reg[9:0]];
    assign drain_s.last  = (rd_reg + 11'h001 == cnt_reg);

    srp_skid u_skid (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_s      (drain_s),
        .out_valid (net_valid),
        .out_data  (net_data),
        .out_last  (net_last),
        .out_ready (net_ready)
    );

    assign tcp_port    = port_reg;
    assign fill_level  = cnt_reg;
    assign pkt_release = rel_reg;
endmodule

// [bench/srp_asserts.sv]
// port checker of packet release timing for the packetizer
// assumes binding to srp_packetizer, one core_clk domain
`timescale 1ns/1ps
module srp_asserts
    import srp_pkg::*;
#(
    parameter int BUF_BYTES = SRP_BUF_BYTES
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // serial byte input
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_ready,
    // configuration
    input wire logic [10:0] pkt_len_limit,
    input wire logic [7:0]  marker1_value,
    input wire logic        marker1_en,
    input wire logic [7:0]  marker2_value,
    input wire logic        marker2_en,
    input wire logic [1:0]  marker_mode,
    input wire logic [15:0] flush_timeout_ms,
    input wire logic [15:0] tcp_port_cfg,
    // status and network side
    input wire logic [15:0] tcp_port,
    input wire logic [10:0] fill_level,
    input wire logic        pkt_release,
    input wire logic        net_valid,
    input wire logic [7:0]  net_data,
    input wire logic        net_last,
    input wire logic        net_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_take; rx_valid && rx_ready; endsequence
    sequence s_keep; s_take ##0 (marker_mode == SRP_MODE_KEEP && marker1_en); endsequence
    property p_len;
        s_take ##0 (pkt_len_limit != 11'h000 && fill_level + 11'h001 == pkt_len_limit) |=> pkt_release;
    endproperty
    property p_m1; s_keep ##0 (rx_data == marker1_value) |=> pkt_release; endproperty
    property p_m2; s_keep ##0 (marker2_en && rx_data == marker2_value) |=> pkt_release; endproperty
    property p_m2_off;
        s_keep ##0 (!marker2_en && rx_data == marker2_value && rx_data != marker1_value
            && pkt_len_limit == 11'h000 && fill_level < 11'h3FE) |=> !pkt_release;
    endproperty
    property p_full; s_take ##0 (fill_level == 11'(BUF_BYTES - 1)) |=> pkt_release; endproperty
    property p_pulse; pkt_release |=> !pkt_release; endproperty
    property p_drain; pkt_release && fill_level != 11'h000 |-> !rx_ready; endproperty
    property p_hold;
        net_valid && !net_ready |=> net_valid && $stable(net_data) && $stable(net_last);
    endproperty
    property p_port; $past(reset_n) |-> tcp_port == $past(tcp_port_cfg); endproperty
    property p_tmo_off; !(rx_valid && rx_ready) && flush_timeout_ms == 16'h0000 |=> !pkt_release; endproperty
    a_len: assert property (p_len) else $error("length release missing");
    a_m1: assert property (p_m1) else $error("first marker release missing");
    a_m2: assert property (p_m2) else $error("second marker release missing");
    a_m2_off: assert property (p_m2_off) else $error("disabled marker released");
    a_full: assert property (p_full) else $error("full release missing");
    a_pulse: assert property (p_pulse) else $error("release pulse too long");
    a_drain: assert property (p_drain) else $error("byte accepted at release");
    a_hold: assert property (p_hold) else $error("stalled word changed");
    a_port: assert property (p_port) else $error("port number not followed");
    a_tmo_off: assert property (p_tmo_off) else $error("idle release while disabled");
endmodule
bind srp_packetizer srp_asserts #(.BUF_BYTES(BUF_BYTES)) srp_asserts_inst (.*);

// [bench/srp_net_sink.sv]
// network side model: takes packet bytes, may stall
// assumes core_clk domain and the packetizer network stream
`timescale 1ns/1ps
module srp_net_sink (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // stream in
    input  wire logic       net_valid,
    input  wire logic [7:0] net_data,
    input  wire logic       net_last,
    output      logic       net_ready,
    // control
    input  wire logic       slow
);
    logic [1:0] phase_reg;
    logic [8:0] q[$];
    always_ff @(posedge core_clk) begin
        phase_reg <= reset_n ? phase_reg + 2'h1 : 2'h0;
        if (reset_n && net_valid && net_ready) begin
            q.push_back({net_last, net_data});
        end
    end
    assign net_ready = !slow || phase_reg == 2'h3;
endmodule

// [bench/tb_top.sv]
// self-checking bench of the serial receive packetizer
// assumes srp_net_sink on the network side, bench sends bytes
`timescale 1ns/1ps
module tb_top
    import srp_pkg::*;
;
    logic        core_clk = 1'b0, reset_n = 1'b0, rx_valid = 1'b0, rx_ready, slow = 1'b0;
    logic        marker1_en = 1'b0, marker2_en = 1'b0, pkt_release, net_valid, net_last, net_ready;
    logic [7:0]  rx_data = 8'h00, marker1_value = 8'hFF, marker2_value = 8'h0D, net_data;
    logic [10:0] pkt_len_limit = 11'h000, fill_level;
    logic [1:0]  marker_mode = SRP_MODE_KEEP;
    logic [15:0] flush_timeout_ms = 16'h0000, tcp_port_cfg = 16'h1234, tcp_port;
    int          failures = 0, samples_checked = 0, k;
    logic [7:0]  exp_q[$];
    srp_packetizer #(.CYC_PER_MS(10)) srp_packetizer_inst (.*);
    srp_net_sink srp_net_sink_inst (.*);
    initial forever #20 core_clk = ~core_clk;
    function automatic int nq();
        return srp_net_sink_inst.q.size();
    endfunction
    task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic send(logic [7:0] b);
        int i;
        @(negedge core_clk);
        rx_valid = 1'b1;
        rx_data = b;
        for (i = 0; i < 5000 && rx_ready !== 1'b1; i++) @(negedge core_clk);
        exp_q.push_back(b);
        @(posedge core_clk);
    endtask
    task automatic idle(int n);
        @(negedge core_clk);
        rx_valid = 1'b0;
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk_pkt(string n);
        int i;
        for (i = 0; i < 5000; i++) begin
            if (nq() > 0 && srp_net_sink_inst.q[$][8] === 1'b1) break;
            @(negedge core_clk);
        end
        cmp(n, 16'(exp_q.size()), 16'(nq()));
        for (i = 0; i < exp_q.size() && i < nq(); i++) begin
            cmp(n, {7'h00, i == exp_q.size() - 1, exp_q[i]}, {7'h00, srp_net_sink_inst.q[i]});
        end
        exp_q.delete();
        srp_net_sink_inst.q.delete();
    endtask
    task automatic t_reset();
        cmp("rx_ready", 16'h0001, 16'(rx_ready));
        cmp("net_valid", 16'h0000, 16'(net_valid));
        cmp("fill_level", 16'h0000, 16'(fill_level));
        cmp("tcp_port", SRP_TCP_PORT_DEF, tcp_port);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        cmp("tcp_port", 16'h1234, tcp_port);
    endtask
    task automatic t_marker();
        marker1_en = 1'b1;
        slow = 1'b1;
        send(8'h11); send(8'h22); send(8'hFF); idle(2);
        chk_pkt("keep");
        marker2_en = 1'b1;
        send(8'h33); send(8'h0D); idle(2);
        chk_pkt("second");
        marker2_en = 1'b0;
        send(8'h0D); send(8'hFF); idle(2);
        chk_pkt("second_off");
        slow = 1'b0;
        marker_mode = SRP_MODE_STRIP;
        send(8'h44); send(8'hFF); void'(exp_q.pop_back()); idle(2);
        chk_pkt("strip");
    endtask
    task automatic t_plus();
        for (k = 1; k <= 2; k++) begin
            marker_mode = (k == 1) ? SRP_MODE_PLUS1 : SRP_MODE_PLUS2;
            send(8'h55); send(8'hFF);
            repeat (k - 1) send(8'h77);
            idle(6);
            cmp("plus_hold", 16'h0000, 16'(nq()));
            send(8'h66); idle(2);
            chk_pkt("plus");
        end
    endtask
    task automatic t_len();
        marker_mode = SRP_MODE_KEEP;
        pkt_len_limit = 11'h003;
        send(8'h01); send(8'h02); send(8'h03); idle(2);
        chk_pkt("length");
        send(8'h04); send(8'h05); send(8'hFF); idle(2);
        chk_pkt("coincident");
        idle(6);
        cmp("single", 16'h0000, 16'(nq()));
        pkt_len_limit = 11'h000;
    endtask
    task automatic t_tmo();
        marker1_en = 1'b0;
        send(8'hA1); idle(200);
        cmp("tmo_off", 16'h0000, 16'(nq()));
        send(8'hA2); idle(1);
        flush_timeout_ms = 16'h000B;
        idle(60);
        send(8'hA3); idle(80);
        cmp("restart", 16'h0000, 16'(nq()));
        cmp("fill", 16'h0003, 16'(fill_level));
        chk_pkt("timeout");
        flush_timeout_ms = 16'h0000;
    endtask
    task automatic t_full();
        int i;
        slow = 1'b1;
        for (i = 0; i < SRP_BUF_BYTES; i++) send(8'(i));
        idle(2);
        chk_pkt("full");
    endtask
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        t_reset(); t_marker(); t_plus(); t_len(); t_tmo(); t_full();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        failures++;
        final_report();
    end
endmodule
